// ==== scdiv_src.sv ====
// Model of the far side: the slow clock that the divider counts.
// Assumes the system clock is free running; run comes from the bench.
`timescale 1ns/1ps
module scdiv_src (
  input wire logic clock,
  input wire logic run,
  output logic div_clk_in
);
  logic [2:0] ph = 3'h0;
  // One process drives the phase count and the clock pin; the clock pin is settled low at the
  // first falling system edge, long before the bench releases reset.
  // Each level lasts eight system cycles, well over the three that the
  // oversampling pins need; the clock stands low while the source idles.
  always @(negedge clock) begin
    if (!run) begin
      ph <= 3'h0;
      div_clk_in <= 1'b0;
    end else begin
      ph <= ph + 3'h1;
      if (ph == 3'h7) begin
        div_clk_in <= ~div_clk_in;
      end
    end
  end
endmodule

// ==== scdiv_sync.sv ====
// Package of shared constants for the divider, and a two-stage pin synchroniser.
// Assumes all pins arrive asynchronously to the one system clock.
package scdiv_pkg;
  localparam int CNT_W = 3;
  localparam logic [2:0] CNT_RST = 3'h0;
  localparam logic [2:0] CNT_STEP = 3'h1;
  localparam int HALF_BIT = 0;
  localparam int QUARTER_BIT = 1;
  localparam int EIGHTH_BIT = 2;
  localparam int PIN_W = 3;
  localparam int PIN_CLK = 0;
  localparam int PIN_EN_N = 1;
  localparam int PIN_CLR = 2;
  localparam logic [2:0] PIN_RST = 3'h0;
  // Gray coded along clear, arm, run.
  typedef enum logic [1:0] {
    SCDIV_CLEAR = 2'h0,
    SCDIV_ARM = 2'h1,
    SCDIV_RUN = 2'h3
  } scdiv_state_e;
endpackage

`timescale 1ns/1ps
module scdiv_sync #(
  parameter int W = 3
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;

  // The first stage feeds only the second stage.
  always_comb begin
    nxt_meta = pin_in;
    nxt_sync = meta_ff;
  end

  // Pins read as low until sampled, as an open pin would.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign pin_sync = sync_ff;
endmodule

// ==== scdiv_top.sv ====
// Synchronous divide by two, four and eight clock generator.
// Assumes the divided clock, enable and clear arrive as slow pins that the
// system clock oversamples; each pin is synchronised before use.
// How it works
// - Three outputs run at one half, quarter and eighth of input rate.
// - One counter register drives all outputs so common edges coincide.
// - Enable changes act only during the low phase of the input clock.
// - Enable is captured on the falling input clock edge.
// - Clear puts dividers into a known, aligned state after power-up.
// - Clock, enable and clear inputs read as logic low only until sampled after reset.
// - Enable high stops dividers at next falling edge, holding the count.
// - Enable low resumes at next falling edge, continuing from held count.
// - Clear released with clock low: outputs follow second rising edge.
`timescale 1ns/1ps
module scdiv_top (
  input wire logic clock,
  input wire logic nrst,
  input wire logic div_clk_in,
  input wire logic div_enable_n,
  input wire logic divider_sync_clear,
  output logic half_rate_out,
  output logic quarter_rate_out,
  output logic eighth_rate_out
);
  logic [scdiv_pkg::PIN_W-1:0] pins_s;
  logic clk_s;
  logic en_n_s;
  logic clr_s;
  logic clk_prev_ff;
  logic rise;
  logic fall;
  logic en_n_ff;
  logic nxt_en_n;
  logic [scdiv_pkg::CNT_W-1:0] cnt_ff;
  logic [scdiv_pkg::CNT_W-1:0] nxt_cnt;
  scdiv_pkg::scdiv_state_e state_ff;
  scdiv_pkg::scdiv_state_e nxt_state;

  // All three pins cross into the system clock domain here.
  scdiv_sync #(
    .W(scdiv_pkg::PIN_W)
  ) u_sync (
    .clock(clock),
    .nrst(nrst),
    .pin_in({divider_sync_clear, div_enable_n, div_clk_in}),
    .pin_sync(pins_s)
  );

  // The synchroniser resets low, so pins count as low until first sampled.
  assign clk_s = pins_s[scdiv_pkg::PIN_CLK];
  assign en_n_s = pins_s[scdiv_pkg::PIN_EN_N];
  assign clr_s = pins_s[scdiv_pkg::PIN_CLR];

  // Edge detection of the oversampled input clock.
  assign rise = clk_s & ~clk_prev_ff;
  assign fall = ~clk_s & clk_prev_ff;

  // Enable flop loads only on falling edges, so a change can never cut a
  // high phase short and leave the stages out of step.
  always_comb begin
    nxt_en_n = en_n_ff;
    if (fall) begin
      nxt_en_n = en_n_s;
    end
  end

  // Divider sequencing: clear, arming after a release with clock low, then running.
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      scdiv_pkg::SCDIV_CLEAR: begin
        if (!clr_s) begin
          // Released with clock low: the first rise is swallowed.
          nxt_state = clk_s ? scdiv_pkg::SCDIV_RUN : scdiv_pkg::SCDIV_ARM;
        end
      end
      scdiv_pkg::SCDIV_ARM: begin
        if (rise) begin
          nxt_state = scdiv_pkg::SCDIV_RUN;
        end
      end
      scdiv_pkg::SCDIV_RUN: begin
        // A held enable freezes the count; release continues it.
        if (rise && !en_n_ff) begin
          nxt_cnt = scdiv_pkg::CNT_W'(cnt_ff + scdiv_pkg::CNT_STEP);
        end
      end
      default: begin
        nxt_state = scdiv_pkg::SCDIV_CLEAR;
      end
    endcase
    // Clear overrides everything and zeroes all stages at once.
    if (clr_s) begin
      nxt_state = scdiv_pkg::SCDIV_CLEAR;
      nxt_cnt = scdiv_pkg::CNT_RST;
    end
  end

  // Registers only; all resets take constants.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      clk_prev_ff <= 1'b0;
      en_n_ff <= 1'b0;
      cnt_ff <= scdiv_pkg::CNT_RST;
      state_ff <= scdiv_pkg::SCDIV_CLEAR;
    end else begin
      clk_prev_ff <= clk_s;
      en_n_ff <= nxt_en_n;
      cnt_ff <= nxt_cnt;
      state_ff <= nxt_state;
    end
  end

  // Each output is one bit of the same counter flop, so no skew.
  assign half_rate_out = cnt_ff[scdiv_pkg::HALF_BIT];
  assign quarter_rate_out = cnt_ff[scdiv_pkg::QUARTER_BIT];
  assign eighth_rate_out = cnt_ff[scdiv_pkg::EIGHTH_BIT];

  // Checks on the divider behaviour.
  property p_count;
    @(posedge clock) disable iff (!nrst)
      rise && !en_n_ff && !clr_s && state_ff == scdiv_pkg::SCDIV_RUN
      |=> cnt_ff == scdiv_pkg::CNT_W'($past(cnt_ff) + scdiv_pkg::CNT_STEP);
  endproperty
  a_count: assert property (p_count)
    else $error("Divider did not advance on an enabled rising edge.");

  property p_common_edge;
    @(posedge clock) disable iff (!nrst)
      $rose(quarter_rate_out) |-> $fell(half_rate_out);
  endproperty
  a_common_edge: assert property (p_common_edge)
    else $error("Quarter rate rose without the half rate falling.");

  property p_low_only;
    @(posedge clock) disable iff (!nrst)
      $changed(cnt_ff) |-> $past(rise) || $past(clr_s);
  endproperty
  a_low_only: assert property (p_low_only)
    else $error("Divider changed away from a rising edge or clear.");

  property p_en_capture;
    @(posedge clock) disable iff (!nrst)
      fall |=> en_n_ff == $past(en_n_s);
  endproperty
  a_en_capture: assert property (p_en_capture)
    else $error("Enable not captured on the falling edge.");

  property p_clear_release;
    @(posedge clock) disable iff (!nrst)
      $fell(clr_s) |-> cnt_ff == scdiv_pkg::CNT_RST;
  endproperty
  a_clear_release: assert property (p_clear_release)
    else $error("Divider not in the cleared state at clear release.");

  property p_freeze;
    @(posedge clock) disable iff (!nrst)
      en_n_ff && !clr_s |=> $stable(cnt_ff);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("Divider moved while frozen.");

  property p_resume;
    @(posedge clock) disable iff (!nrst)
      $fell(en_n_ff) |-> $past(fall);
  endproperty
  a_resume: assert property (p_resume)
    else $error("Enable released away from a falling edge.");

  property p_arm_skip;
    @(posedge clock) disable iff (!nrst)
      state_ff == scdiv_pkg::SCDIV_ARM && rise && !clr_s
      |=> $stable(cnt_ff) && state_ff == scdiv_pkg::SCDIV_RUN;
  endproperty
  a_arm_skip: assert property (p_arm_skip)
    else $error("First rising edge after release was not skipped.");

  property p_clear_hold;
    @(posedge clock) disable iff (!nrst)
      clr_s |=> cnt_ff == scdiv_pkg::CNT_RST;
  endproperty
  a_clear_hold: assert property (p_clear_hold)
    else $error("Outputs not held low during clear.");

  // The slowest output only rises when both faster ones fall with it.
  property p_eighth_edge;
    @(posedge clock) disable iff (!nrst)
      $rose(eighth_rate_out)
      |-> $fell(quarter_rate_out) && $fell(half_rate_out);
  endproperty
  a_eighth_edge: assert property (p_eighth_edge)
    else $error("Eighth rate rose without both faster outputs falling.");

  // The enable flop may only move while the sampled input clock is low.
  property p_en_low_phase;
    @(posedge clock) disable iff (!nrst)
      $changed(en_n_ff) |-> !clk_prev_ff;
  endproperty
  a_en_low_phase: assert property (p_en_low_phase)
    else $error("Enable flop moved while the input clock was high.");

  // Every counted step toggles the half rate output.
  property p_half_toggle;
    @(posedge clock) disable iff (!nrst)
      $changed(cnt_ff) && !$past(clr_s)
      |-> half_rate_out != $past(half_rate_out);
  endproperty
  a_half_toggle: assert property (p_half_toggle)
    else $error("Half rate output did not toggle on a counted step.");

  // A release seen while the input clock is low must arm, not run.
  property p_arm_entry;
    @(posedge clock) disable iff (!nrst)
      state_ff == scdiv_pkg::SCDIV_CLEAR && !clr_s && !clk_s
      |=> state_ff == scdiv_pkg::SCDIV_ARM;
  endproperty
  a_arm_entry: assert property (p_arm_entry)
    else $error("Release with the input clock low did not arm.");

  c_wrap: cover property (@(posedge clock) disable iff (!nrst)
    $past(cnt_ff) == 3'h7 && cnt_ff == scdiv_pkg::CNT_RST && !$past(clr_s));
  c_freeze: cover property (@(posedge clock) disable iff (!nrst)
    en_n_ff && rise);
  c_arm: cover property (@(posedge clock) disable iff (!nrst)
    state_ff == scdiv_pkg::SCDIV_ARM && rise);
  // Resume after a freeze, and a release made while the clock stands high.
  c_resume: cover property (@(posedge clock) disable iff (!nrst)
    $fell(en_n_ff));
  c_hot_release: cover property (@(posedge clock) disable iff (!nrst)
    state_ff == scdiv_pkg::SCDIV_CLEAR && !clr_s && clk_s);
endmodule

// ==== tb_scdiv_top.sv ====
// Self-checking bench for the divide by two, four and eight block.
// Assumes the source model toggles its clock every eight system cycles.
`timescale 1ns/1ps
module tb_scdiv_top;
  typedef struct {logic en_n; logic [2:0] exp;} scdiv_row_s;
  // Enable level set before each falling edge, count after the next rise.
  scdiv_row_s rows [11] = '{'{1'b0, 3'h0}, '{1'b0, 3'h1}, '{1'b0, 3'h2},
    '{1'b1, 3'h2}, '{1'b1, 3'h2}, '{1'b0, 3'h3}, '{1'b0, 3'h4},
    '{1'b0, 3'h5}, '{1'b0, 3'h6}, '{1'b0, 3'h7}, '{1'b0, 3'h0}};
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic div_enable_n = 1'b0;
  logic divider_sync_clear = 1'b1;
  logic run = 1'b0;
  logic div_clk_in;
  logic half_rate_out;
  logic quarter_rate_out;
  logic eighth_rate_out;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  // Free running system clock.
  always #5 clock = ~clock;
  scdiv_src SRC (.clock(clock), .run(run), .div_clk_in(div_clk_in));
  scdiv_top DUT (
    .clock(clock),
    .nrst(nrst),
    .div_clk_in(div_clk_in),
    .div_enable_n(div_enable_n),
    .divider_sync_clear(divider_sync_clear),
    .half_rate_out(half_rate_out),
    .quarter_rate_out(quarter_rate_out),
    .eighth_rate_out(eighth_rate_out)
  );
  task automatic test_done();
    if (n_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [2:0] exp);
    checks_done++;
    if ({eighth_rate_out, quarter_rate_out, half_rate_out} !== exp) begin
      n_errors++;
      $display("[ERR] divider outputs expected %h seen %h", exp,
        {eighth_rate_out, quarter_rate_out, half_rate_out});
    end
  endtask
  // Five cycles after a rise the outputs have settled and the source is
  // still high, so the next enable level lands before the falling edge.
  task automatic rise_chk(input logic [2:0] exp);
    @(posedge div_clk_in);
    repeat (5) @(negedge clock);
    chk(exp);
  endtask
  // A hang is cut short well after the few hundred cycles the run needs.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      test_done();
    end
  end
  // Clear is released while the source stands low, so the first rise is
  // skipped; then the table walks freeze, resume and the wrap.
  initial begin
    repeat (12) @(negedge clock);
    nrst = 1'b1;
    repeat (4) @(negedge clock);
    chk(3'h0);
    divider_sync_clear = 1'b0;
    repeat (4) @(negedge clock);
    // Non-blocking, so the source sees the start at a defined edge.
    run <= 1'b1;
    foreach (rows[i]) begin
      div_enable_n = rows[i].en_n;
      rise_chk(rows[i].exp);
    end
    divider_sync_clear = 1'b1;
    rise_chk(3'h0);
    rise_chk(3'h0);
    divider_sync_clear = 1'b0;
    rise_chk(3'h1);
    rise_chk(3'h2);
    // An enable pulse that ends before the falling edge must not freeze.
    div_enable_n = 1'b1;
    repeat (2) @(negedge clock);
    div_enable_n = 1'b0;
    rise_chk(3'h3);
    @(negedge clock);
    nrst = 1'b0;
    #1;
    chk(3'h0);
    test_done();
  end
endmodule
